// >>> rtl/can_rx_store.sv
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ns
module can_rx_store (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [can_rx_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Received frame from protocol engine
  input wire logic rx_frame_i,
  input wire logic [28:0] rx_id_i,
  input wire logic rx_ext_i,
  input wire logic rx_remote_i,
  input wire logic [3:0] rx_dlc_i,
  input wire logic [63:0] rx_data_i,
  // Receive error events from protocol engine
  input wire logic rx_err_minor_i,
  input wire logic rx_err_major_i,
  // Status outputs
  output logic irq_o,
  output logic err_passive_o
);
  import can_rx_pkg::*;

  // Buffer storage
  logic [7:0] payload_q [BUF_N][BYTE_N];
  logic [3:0] dlc_q [BUF_N];
  logic remote_q [BUF_N];
  logic [BUF_N-1:0] full_q;

  // Filter storage
  logic [7:0] filt_high_q [FILT_N];
  logic [FILT_N-1:0] filt_ext_q;

  // Interrupt and bus state
  logic [ST_W-1:0] status_q;
  logic [ST_W-1:0] mask_q;
  logic [ST_W-1:0] status_set;
  logic irq_q;
  logic passive_prev_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // Frame handling terms
  logic dlc_ok;
  logic [7:0] id_high;
  logic [FILT_N-1:0] hit;
  logic [BUF_N-1:0] store_en;
  logic overflow;
  logic accepted;

  // Decoded register port terms
  logic in_buf_region;
  logic in_byte_region;
  logic [BUF_N-1:0] buf_sel;
  logic [2:0] byte_idx;
  logic len_hit;
  logic [FILT_N-1:0] filt_high_hit;
  logic [FILT_N-1:0] filt_ctrl_hit;

  // Per-buffer strobes and read-back words
  logic [BUF_N-1:0] byte_wr;
  logic [BUF_N-1:0] len_wr;
  logic [BUF_N-1:0] full_clr;
  logic [7:0] len_word [BUF_N];
  logic [BYTE_N-1:0] byte_live;
  logic [$clog2(BUF_N)-1:0] buf_idx;

  rx_err_if err_bus ();

  // Tally events; a frame handed over complete counts as a good reception
  assign err_bus.err_minor = rx_err_minor_i;
  assign err_bus.err_major = rx_err_major_i;
  assign err_bus.rx_ok = rx_frame_i;

  rx_fault_counter u_tally (
    .ref_clk_i (ref_clk_i),
    .rst_i (rst_i),
    .err (err_bus.counter)
  );

  // Length code check
  assign dlc_ok = (rx_dlc_i <= DLC_MAX);

  // Compared identifier byte depends on frame format
  assign id_high = rx_ext_i ? rx_id_i[28:21] : rx_id_i[10:3];

  // Filter match per filter; format must agree with the select bit
  genvar gf;
  generate
    for (gf = 0; gf < FILT_N; gf++) begin : g_hit
      assign hit[gf] = rx_frame_i && dlc_ok && (rx_ext_i == filt_ext_q[gf])
        && (id_high == filt_high_q[gf]);
    end
  endgenerate

  // Filter n steers to buffer n; filter 0 has priority when both match
  always_comb begin
    store_en = '0;
    overflow = 1'b0;
    accepted = 1'b0;
    if (hit[0]) begin
      accepted = 1'b1;
      if (!full_q[0]) begin
        store_en[0] = 1'b1;
      end else begin
        overflow = 1'b1;
      end
    end else if (hit[1]) begin
      accepted = 1'b1;
      if (!full_q[1]) begin
        store_en[1] = 1'b1;
      end else begin
        overflow = 1'b1;
      end
    end
  end

  // Register port decode
  always_comb begin
    in_buf_region = !reg_addr_i[REGION_BIT];
    in_byte_region = in_buf_region && !reg_addr_i[BYTE_REGION_BIT];
    byte_idx = reg_addr_i[2:0];
    len_hit = in_buf_region &&
      (reg_addr_i[BUF_SEL_BIT-1:0] == A_LEN_OFS[BUF_SEL_BIT-1:0]);
    buf_sel = '0;
    buf_sel[reg_addr_i[BUF_SEL_BIT]] = in_buf_region;
    buf_idx = reg_addr_i[BUF_SEL_BIT];
  end

  // Filter register decode; two bytes per filter, high byte first
  generate
    for (gf = 0; gf < FILT_N; gf++) begin : g_fdec
      assign filt_high_hit[gf] = (reg_addr_i == A_FILT_BASE + ADDR_W'(2 * gf));
      assign filt_ctrl_hit[gf] = (reg_addr_i == A_FILT_BASE + ADDR_W'(2 * gf + 1));
    end
  endgenerate

  genvar gb;
  genvar gy;

  // Bytes inside the received length; the rest keep their old contents
  generate
    for (gy = 0; gy < BYTE_N; gy++) begin : g_live
      assign byte_live[gy] = (4'(gy) < rx_dlc_i);
    end
  endgenerate

  // Software strobes per buffer, kept apart so the hardware-wins order reads plainly
  generate
    for (gb = 0; gb < BUF_N; gb++) begin : g_sw
      assign byte_wr[gb] = reg_wr_i && buf_sel[gb] && in_byte_region;
      assign len_wr[gb] = reg_wr_i && buf_sel[gb] && len_hit;
      assign full_clr[gb] = reg_wr_i && (reg_addr_i == A_BUF_CTRL) && reg_wdata_i[gb];
      // Length word; reserved bits read zero
      always_comb begin
        len_word[gb] = 8'h00;
        len_word[gb][LEN_REMOTE_BIT] = remote_q[gb];
        len_word[gb][3:0] = dlc_q[gb];
      end
    end
  endgenerate

  // Per-buffer storage
  generate
    for (gb = 0; gb < BUF_N; gb++) begin : g_buf
      // Payload bytes; only bytes inside the length are written, the rest keep
      for (gy = 0; gy < BYTE_N; gy++) begin : g_byte
        always_ff @(posedge ref_clk_i) begin
          if (rst_i) begin
            payload_q[gb][gy] <= 8'h00;
          end else if (store_en[gb] && byte_live[gy]) begin
            payload_q[gb][gy] <= rx_data_i[8*gy +: 8];
          end else if (byte_wr[gb] && (byte_idx == 3'(gy))) begin
            payload_q[gb][gy] <= reg_wdata_i;
          end
        end
      end

      // Length and remote flag; a frame landing beats a software write
      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          dlc_q[gb] <= 4'h0;
          remote_q[gb] <= 1'b0;
        end else if (store_en[gb]) begin
          dlc_q[gb] <= rx_dlc_i;
          remote_q[gb] <= rx_remote_i;
        end else if (len_wr[gb]) begin
          dlc_q[gb] <= reg_wdata_i[3:0];
          remote_q[gb] <= reg_wdata_i[LEN_REMOTE_BIT];
        end
      end

      // Full flag; a new frame sets it even if software clears it now
      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          full_q[gb] <= 1'b0;
        end else if (store_en[gb]) begin
          full_q[gb] <= 1'b1;
        end else if (full_clr[gb]) begin
          full_q[gb] <= 1'b0;
        end
      end
    end
  endgenerate

  // Filter registers, software only
  generate
    for (gf = 0; gf < FILT_N; gf++) begin : g_filt
      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          filt_high_q[gf] <= 8'h00;
          filt_ext_q[gf] <= 1'b0;
        end else if (reg_wr_i && filt_high_hit[gf]) begin
          filt_high_q[gf] <= reg_wdata_i;
        end else if (reg_wr_i && filt_ctrl_hit[gf]) begin
          filt_ext_q[gf] <= reg_wdata_i[FILT_EXT_BIT];
        end
      end
    end
  endgenerate

  // Events that raise interrupt status
  always_comb begin
    status_set = '0;
    status_set[ST_RX0] = store_en[0];
    status_set[ST_RX1] = store_en[1];
    status_set[ST_OVF] = overflow;
    status_set[ST_BADLEN] = rx_frame_i && !dlc_ok;
    status_set[ST_PASSIVE] = err_bus.passive && !passive_prev_q;
  end

  // Edge memory for entering error passive
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      passive_prev_q <= 1'b0;
    end else begin
      passive_prev_q <= err_bus.passive;
    end
  end

  // Sticky status; a read clears, but an event in the same cycle survives
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      status_q <= '0;
    end else if (reg_rd_i && (reg_addr_i == A_STATUS)) begin
      status_q <= status_set;
    end else begin
      status_q <= status_q | status_set;
    end
  end

  // Interrupt mask
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mask_q <= '0;
    end else if (reg_wr_i && (reg_addr_i == A_MASK)) begin
      mask_q <= reg_wdata_i[ST_W-1:0];
    end
  end

  // Interrupt line follows the status one cycle late, from a flop
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q);
    end
  end

  // Read mux; unmapped and reserved bits return zero
  always_comb begin
    rdata_d = 8'h00;
    if (in_byte_region) begin
      rdata_d = payload_q[buf_idx][byte_idx];
    end else if (len_hit) begin
      rdata_d = len_word[buf_idx];
    end else if (reg_addr_i == A_TALLY) begin
      rdata_d = err_bus.tally;
    end else if (reg_addr_i == A_STATUS) begin
      rdata_d[ST_W-1:0] = status_q;
    end else if (reg_addr_i == A_MASK) begin
      rdata_d[ST_W-1:0] = mask_q;
    end else if (reg_addr_i == A_BUF_CTRL) begin
      rdata_d[BUF_N-1:0] = full_q;
      rdata_d[CTRL_PASSIVE_BIT] = err_bus.passive;
    end else begin
      for (int f = 0; f < FILT_N; f++) begin
        if (filt_high_hit[f]) begin
          rdata_d = filt_high_q[f];
        end
        if (filt_ctrl_hit[f]) begin
          rdata_d[FILT_EXT_BIT] = filt_ext_q[f];
        end
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_i) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // Tally writes are ignored; the tally is read only to software
  assign reg_rdata_o = rdata_q;
  assign irq_o = irq_q;
  assign err_passive_o = err_bus.passive;

  // Accept flag has no reader here; it is tied to a spare net
  logic unused_bits;
  assign unused_bits = accepted;

endmodule // can_rx_store

// >>> rtl/can_rx_pkg.sv
// Behaviour
// - Length codes 0 to 8 give 0 to 8 payload bytes; codes 9 and up are invalid.
// - Each receive buffer has eight software read/write payload byte registers, index 0 to 7.
// - Eight-bit software read-only receive error tally, CAN counting, cleared at reset.
// - Tally above 127 puts the controller in error passive state.
// - The receive error tally never causes bus-off by any value.
// - Each filter has a writable high identifier byte: ID 10:3 or extended 28:21.
// - Filter extended select one accepts only extended frames, zero only standard.
// - Length code sits in length register bits 3:0 beside the remote request flag.
package can_rx_pkg;

  // Sizes
  localparam int BUF_N = 2;
  localparam int FILT_N = 2;
  localparam int BYTE_N = 8;
  localparam int ADDR_W = 6;

  // Length code decode
  localparam logic [3:0] DLC_MAX = 4'h8;

  // Register map, byte addresses
  localparam logic [ADDR_W-1:0] A_LEN_OFS = 6'h08;
  localparam logic [ADDR_W-1:0] A_FILT_BASE = 6'h20;
  localparam logic [ADDR_W-1:0] A_TALLY = 6'h28;
  localparam logic [ADDR_W-1:0] A_STATUS = 6'h29;
  localparam logic [ADDR_W-1:0] A_MASK = 6'h2A;
  localparam logic [ADDR_W-1:0] A_BUF_CTRL = 6'h2B;
  localparam int REGION_BIT = 5;
  localparam int BUF_SEL_BIT = 4;
  localparam int BYTE_REGION_BIT = 3;

  // Field positions
  localparam int LEN_REMOTE_BIT = 6;
  localparam int FILT_EXT_BIT = 3;
  localparam int CTRL_PASSIVE_BIT = 2;

  // Status and mask bits
  localparam int ST_RX0 = 0;
  localparam int ST_RX1 = 1;
  localparam int ST_OVF = 2;
  localparam int ST_BADLEN = 3;
  localparam int ST_PASSIVE = 4;
  localparam int ST_W = 5;

  // Receive error tally figures
  localparam logic [7:0] REC_RESET = 8'h00;
  localparam logic [7:0] REC_PASSIVE_LIMIT = 8'h7F;
  localparam logic [7:0] REC_MAX = 8'hFF;
  localparam logic [7:0] REC_STEP_MINOR = 8'h01;
  localparam logic [7:0] REC_STEP_MAJOR = 8'h08;
  localparam logic [7:0] REC_RELOAD = 8'h77;

endpackage

// >>> rtl/rx_err_if.sv
`timescale 1ns/1ns
// Error events into the tally and its state back out
interface rx_err_if;
  logic err_minor;
  logic err_major;
  logic rx_ok;
  logic [7:0] tally;
  logic passive;

  modport counter (input err_minor, input err_major, input rx_ok, output tally, output passive);
  modport user (output err_minor, output err_major, output rx_ok, input tally, input passive);
endinterface

// >>> rtl/rx_fault_counter.sv
`timescale 1ns/1ns
module rx_fault_counter (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Events and state
  rx_err_if.counter err
);
  import can_rx_pkg::*;

  logic [7:0] tally_q;
  logic [7:0] tally_d;
  logic passive_q;
  logic [8:0] sum;

  // Next tally value; major error wins over minor over success
  always_comb begin
    sum = 9'h000;
    tally_d = tally_q;
    if (err.err_major) begin
      sum = {1'b0, tally_q} + {1'b0, REC_STEP_MAJOR};
      tally_d = sum[8] ? REC_MAX : sum[7:0];
    end else if (err.err_minor) begin
      sum = {1'b0, tally_q} + {1'b0, REC_STEP_MINOR};
      tally_d = sum[8] ? REC_MAX : sum[7:0];
    end else if (err.rx_ok) begin
      if (tally_q > REC_PASSIVE_LIMIT) begin
        tally_d = REC_RELOAD;
      end else if (tally_q != REC_RESET) begin
        tally_d = tally_q - REC_STEP_MINOR;
      end
    end
  end

  // Tally and passive flag; saturating, so no wrap back to active
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tally_q <= REC_RESET;
      passive_q <= 1'b0;
    end else begin
      tally_q <= tally_d;
      passive_q <= (tally_d > REC_PASSIVE_LIMIT);
    end
  end

  assign err.tally = tally_q;
  assign err.passive = passive_q;
endmodule // rx_fault_counter

// >>> verif/can_rx_store_monitor.sv
`timescale 1ns/1ns
module can_rx_store_monitor
  import can_rx_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [can_rx_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // Engine events and status
  input wire logic rx_frame_i,
  input wire logic rx_err_minor_i,
  input wire logic rx_err_major_i,
  input wire logic irq_o,
  input wire logic err_passive_o
);
  logic [3:0] hist_q;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // Recent causes of an interrupt; status may lag the event by a stage
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      hist_q <= 4'h0;
    end else begin
      hist_q <= {hist_q[2:0], rx_frame_i | rx_err_major_i | rx_err_minor_i | reg_wr_i};
    end
  end
  sequence s_filt_wr; reg_wr_i && reg_addr_i == A_FILT_BASE; endsequence
  sequence s_filt_rd; reg_rd_i && reg_addr_i == A_FILT_BASE; endsequence
  sequence s_byte_wr; reg_wr_i && reg_addr_i[5:3] == 3'h0 && !rx_frame_i; endsequence
  sequence s_byte_rd; reg_rd_i && reg_addr_i == $past(reg_addr_i) && !rx_frame_i; endsequence
  property p_filt_rw; s_filt_wr ##1 s_filt_rd |=> reg_rdata_o == $past(reg_wdata_i, 2); endproperty
  property p_byte_rw; s_byte_wr ##1 s_byte_rd |=> reg_rdata_o == $past(reg_wdata_i, 2); endproperty
  property p_rd_idle; !$past(reg_rd_i) |-> reg_rdata_o == 8'h00; endproperty
  property p_pas_rise; $rose(err_passive_o) |-> $past(rx_err_major_i || rx_err_minor_i); endproperty
  property p_pas_fall;
    $fell(err_passive_o) |-> $past(rx_frame_i) && !$past(rx_err_major_i || rx_err_minor_i);
  endproperty
  property p_tally_msb; reg_rd_i && reg_addr_i == A_TALLY |=> reg_rdata_o[7] == $past(err_passive_o);
  endproperty
  property p_ctrl_pas;
    reg_rd_i && reg_addr_i == A_BUF_CTRL |=> reg_rdata_o[CTRL_PASSIVE_BIT] == $past(err_passive_o);
  endproperty
  property p_irq_rise; $rose(irq_o) |-> |hist_q[3:1]; endproperty
  property p_irq_fall; $fell(irq_o) |-> $past(reg_rd_i || reg_wr_i, 2); endproperty
  a_filt_rw: assert property (p_filt_rw) else $error("filter byte readback wrong");
  a_byte_rw: assert property (p_byte_rw) else $error("payload byte readback wrong");
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  a_pas_rise: assert property (p_pas_rise) else $error("passive rose without error");
  a_pas_fall: assert property (p_pas_fall) else $error("passive fell without success");
  a_tally_msb: assert property (p_tally_msb) else $error("tally top bit vs passive");
  a_ctrl_pas: assert property (p_ctrl_pas) else $error("control passive bit wrong");
  a_irq_rise: assert property (p_irq_rise) else $error("interrupt rose without cause");
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell without access");
endmodule // can_rx_store_monitor

// >>> verif/can_node_model.sv
`timescale 1ns/1ns
module can_node_model (
  // Clock
  input wire logic ref_clk_i,
  // Received frame toward the store
  output logic rx_frame_o,
  output logic [28:0] rx_id_o,
  output logic rx_ext_o,
  output logic rx_remote_o,
  output logic [3:0] rx_dlc_o,
  output logic [63:0] rx_data_o,
  // Error events
  output logic err_minor_o,
  output logic err_major_o
);
  // Quiet lines at time zero
  initial begin
    {rx_frame_o, rx_id_o, rx_ext_o, rx_remote_o, rx_dlc_o, rx_data_o} = '0;
    {err_minor_o, err_major_o} = 2'h0;
  end
  // One-cycle frame; id, length and data inverted after so stale values never match
  task automatic send_frame(input logic [28:0] id, input logic ext, input logic rem,
                            input logic [3:0] dlc, input logic [63:0] data);
    @(posedge ref_clk_i);
    rx_frame_o <= 1'b1;
    rx_id_o <= id;
    rx_ext_o <= ext;
    rx_remote_o <= rem;
    rx_dlc_o <= dlc;
    rx_data_o <= data;
    @(posedge ref_clk_i);
    rx_frame_o <= 1'b0;
    rx_id_o <= ~id;
    rx_dlc_o <= ~dlc;
    rx_data_o <= ~data;
  endtask
  // One-cycle error pulse, major or minor
  task automatic send_err(input logic major);
    @(posedge ref_clk_i);
    err_major_o <= major;
    err_minor_o <= !major;
    @(posedge ref_clk_i);
    err_major_o <= 1'b0;
    err_minor_o <= 1'b0;
  endtask
endmodule // can_node_model

// >>> verif/tb_can_rx_store.sv
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_can_rx_store;
  import can_rx_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic fr, ext, rem, mi, ma, irq, pas;
  logic [28:0] id;
  logic [3:0] dlc;
  logic [63:0] data;
  int fails = 0;
  int checks = 0;
  can_rx_store can_rx_store_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .rx_frame_i(fr),
    .rx_id_i(id), .rx_ext_i(ext), .rx_remote_i(rem), .rx_dlc_i(dlc), .rx_data_i(data),
    .rx_err_minor_i(mi), .rx_err_major_i(ma), .irq_o(irq), .err_passive_o(pas));
  can_node_model can_node_model_inst (.ref_clk_i(ref_clk_i), .rx_frame_o(fr), .rx_id_o(id),
    .rx_ext_o(ext), .rx_remote_o(rem), .rx_dlc_o(dlc), .rx_data_o(data), .err_minor_o(mi),
    .err_major_o(ma));
  // 50 MHz clock
  initial begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  // Register bus cycles, one strobe cycle each
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge ref_clk_i);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    @(negedge ref_clk_i);
    `CHK(rdata, e)
  endtask
  // Write then read back with no gap between the strobes
  task automatic wr_rd(input logic [5:0] a, input logic [7:0] v);
    @(posedge ref_clk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge ref_clk_i);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    @(negedge ref_clk_i);
    `CHK(rdata, v)
  endtask
  task automatic wrap_up;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Reset values, payload bytes, read-only tally, unmapped place
  task automatic t_regs;
    rd_chk(A_TALLY, 8'h00);
    rd_chk(A_FILT_BASE, 8'h00);
    for (int m = 0; m < BYTE_N; m++) wr_reg(6'(m), 8'hA0 | 8'(m));
    for (int m = 0; m < BYTE_N; m++) rd_chk(6'(m), 8'hA0 | 8'(m));
    wr_rd(6'h07, 8'h3C);
    wr_rd(A_FILT_BASE, 8'hC3);
    wr_reg(A_FILT_BASE + 6'h01, 8'hFF);
    rd_chk(A_FILT_BASE + 6'h01, 8'h08);
    wr_reg(A_FILT_BASE + 6'h01, 8'h00);
    wr_reg(A_LEN_OFS, 8'hFF);
    rd_chk(A_LEN_OFS, 8'h4F);
    wr_reg(A_TALLY, 8'h55);
    rd_chk(A_TALLY, 8'h00);
    rd_chk(6'h3F, 8'h00);
    $display("t_regs done");
  endtask
  // Standard and extended filtering, partial length, remote flag
  task automatic t_filter;
    wr_reg(A_FILT_BASE, 8'h5A);
    wr_reg(A_FILT_BASE + 6'h02, 8'h5A);
    wr_reg(A_FILT_BASE + 6'h03, 8'h08);
    can_node_model_inst.send_frame({18'h0, 8'h5A, 3'h5}, 1'b0, 1'b1, 4'h3, 64'h8877665544332211);
    rd_chk(6'h02, 8'h33);
    rd_chk(6'h03, 8'hA3);
    rd_chk(A_LEN_OFS, 8'h43);
    can_node_model_inst.send_frame({8'h5A, 21'h0}, 1'b1, 1'b0, 4'h8, 64'hF000000000000000);
    rd_chk(6'h17, 8'hF0);
    rd_chk(6'h18, 8'h08);
    rd_chk(A_STATUS, 8'h03);
    can_node_model_inst.send_frame({18'h0, 8'h5A, 3'h1}, 1'b0, 1'b0, 4'h1, 64'h99);
    rd_chk(A_STATUS, 8'h04);
    rd_chk(6'h00, 8'h11);
    $display("t_filter done");
  endtask
  // Every invalid length code is refused
  task automatic t_dlc;
    wr_reg(A_BUF_CTRL, 8'h03);
    for (int c = 9; c < 16; c++) begin
      can_node_model_inst.send_frame({18'h0, 8'h5A, 3'h0}, 1'b0, 1'b0, 4'(c), '1);
      rd_chk(A_STATUS, 8'h08);
      rd_chk(6'h00, 8'h11);
    end
    $display("t_dlc done");
  endtask
  // Passive boundary, interrupt, reload on success, saturation
  task automatic t_tally;
    wr_reg(A_MASK, 8'h10);
    repeat (15) can_node_model_inst.send_err(1'b1);
    repeat (7) can_node_model_inst.send_err(1'b0);
    rd_chk(A_TALLY, 8'h7F);
    `CHK(pas, 1'b0)
    can_node_model_inst.send_err(1'b0);
    repeat (3) @(negedge ref_clk_i);
    `CHK(pas, 1'b1)
    `CHK(irq, 1'b1)
    rd_chk(A_TALLY, 8'h80);
    rd_chk(A_STATUS, 8'h10);
    repeat (2) @(negedge ref_clk_i);
    `CHK(irq, 1'b0)
    can_node_model_inst.send_frame(29'h0, 1'b0, 1'b0, 4'h9, 64'h0);
    rd_chk(A_TALLY, 8'h77);
    `CHK(pas, 1'b0)
    repeat (20) can_node_model_inst.send_err(1'b1);
    rd_chk(A_TALLY, 8'hFF);
    rd_chk(A_BUF_CTRL, 8'h04);
    $display("t_tally done");
  endtask
  // Main sequence
  initial begin
    repeat (20) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_filter();
    t_dlc();
    t_tally();
    wrap_up();
  end
  // Hang guard, far beyond the few hundred cycles of the tests
  initial begin
    #200000;
    fails++;
    wrap_up();
  end
endmodule // tb_can_rx_store
bind can_rx_store can_rx_store_monitor can_rx_store_monitor_inst (.ref_clk_i(ref_clk_i),
  .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .rx_frame_i(rx_frame_i),
  .rx_err_minor_i(rx_err_minor_i), .rx_err_major_i(rx_err_major_i), .irq_o(irq_o),
  .err_passive_o(err_passive_o));
